/* File: logic/chip_mode_pkg.sv */
package chip_mode_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_OPERATING_MODE = 12'h200;
    localparam logic [11:0] ADDR_DECIMATION     = 12'h201;
    localparam logic [7:0]  RESET_OPERATING     = 8'h00;
    localparam logic [7:0]  RESET_DECIMATION    = 8'h00;
    localparam logic [11:0] ADDR_TIMESTAMP      = 12'h202;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int          Q_IGNORE_BIT        = 5;
    localparam logic [7:0]  OPERATING_WR_MASK   = 8'h2f;
    localparam logic [7:0]  DECIMATION_WR_MASK  = 8'h0f;
    localparam logic [3:0]  APP_FULL_BANDWIDTH  = 4'h0;
    localparam logic [3:0]  APP_TWO_PATHS       = 4'h2;
    localparam logic [3:0]  DECIM_BYPASS        = 4'h0;

    // Bundle of mode outputs steering the conversion path.
    typedef struct packed {
        logic       q_path_enable;
        logic       first_downconverter_en;
        logic       second_downconverter_en;
        logic       downconverter_bypass;
        logic [3:0] decimation_code;
    } path_ctrl_type;

endpackage

/* File: logic/chip_mode_config.sv */
// Contract
// - Real-only bit drops quadrature path.
// - Application mode selects downconverter paths.
// - Timestamp pulse leaves link, monitor alone.
// - Captured pulse tags the coinciding sample.
// - Decimation code zero bypasses all downconverters.
`timescale 1ns/10ps
module chip_mode_config
(
    input  wire logic                          core_clk,
    input  wire logic                          rstn,
    input  wire logic [11:0]                   reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [7:0]                         reg_rdata,
    input  wire logic                          timestamp_mode,
    input  wire logic                          sync_pulse_in,
    input  wire logic                          sample_valid,
    output chip_mode_pkg::path_ctrl_type       path_ctrl,
    output logic                               sample_tag,
    output logic                               divider_reset
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Write strobe decode for one register address. Both configuration
    // registers share it so that their decode can never drift apart.
    // A write to any other address matches neither and is dropped.
    function automatic logic write_hit
    (
        input logic        wr,
        input logic [11:0] addr,
        input logic [11:0] target
    );
        return wr && (addr == target);
    endfunction

    // Both downconverter paths run only for the two-path code, and only
    // while the decimation ratio does not bypass them. Both enables use
    // this one decode, so they always change together.
    function automatic logic two_paths_on
    (
        input logic [3:0] mode,
        input logic       bypass_now
    );
        return !bypass_now && (mode == chip_mode_pkg::APP_TWO_PATHS);
    endfunction

    // A synchronised level is trusted once stages two and three hold it.
    // Stage one is never judged, since it may still be settling.
    function automatic logic stages_agree
    (
        input logic [2:0] stages
    );
        return stages[1] == stages[2];
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] operating_r;
    logic [7:0] decimation_r;
    logic [7:0] tag_count_r;
    logic [2:0] sync_sr_r;
    logic       sync_seen_r;
    logic       tag_pending_r;

    // Reserved bits are masked so they always read back as zero.
    // The mask also keeps a careless write from setting a reserved bit.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            operating_r <= chip_mode_pkg::RESET_OPERATING;
        else if (write_hit(reg_wr, reg_addr, chip_mode_pkg::ADDR_OPERATING_MODE))
            operating_r <= reg_wdata & chip_mode_pkg::OPERATING_WR_MASK;
    end

    // Undefined codes are stored as written; software must avoid them.
    // Checking every code here would cost a table for no gain in safety.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            decimation_r <= chip_mode_pkg::RESET_DECIMATION;
        else if (write_hit(reg_wr, reg_addr, chip_mode_pkg::ADDR_DECIMATION))
            decimation_r <= reg_wdata & chip_mode_pkg::DECIMATION_WR_MASK;
    end

    // Read data stands one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            unique case (reg_addr)
                chip_mode_pkg::ADDR_OPERATING_MODE: reg_rdata <= operating_r;
                chip_mode_pkg::ADDR_DECIMATION:     reg_rdata <= decimation_r;
                chip_mode_pkg::ADDR_TIMESTAMP:      reg_rdata <= tag_count_r;
                default:                            reg_rdata <= 8'h00;
            endcase
        else
            reg_rdata <= 8'h00;
    end

    // ------------------------------------------------------------
    // Path control decode
    // ------------------------------------------------------------
    // Decode of the stored fields, shared by the steering logic below.
    logic [3:0]                   app_mode;
    logic [3:0]                   decim_code;
    logic                         bypass;
    chip_mode_pkg::path_ctrl_type path_ctrl_nxt;

    // Field views of the two registers; only the low nibble carries a code.
    assign app_mode   = operating_r[3:0];
    assign decim_code = decimation_r[3:0];
    assign bypass     = (decim_code == chip_mode_pkg::DECIM_BYPASS);

    // Next steering word. Bypass overrides the application mode so full-rate
    // data never meets a filter; codes other than the two defined ones leave
    // every downconverter off rather than guess at an arrangement.
    always_comb
    begin
        path_ctrl_nxt                         = '0;
        path_ctrl_nxt.q_path_enable           = ~operating_r[chip_mode_pkg::Q_IGNORE_BIT];
        path_ctrl_nxt.first_downconverter_en  = two_paths_on(app_mode, bypass);
        path_ctrl_nxt.second_downconverter_en = two_paths_on(app_mode, bypass);
        path_ctrl_nxt.downconverter_bypass    = bypass || (app_mode == chip_mode_pkg::APP_FULL_BANDWIDTH);
        path_ctrl_nxt.decimation_code         = decim_code;
    end

    // The word is registered so the conversion path sees one clean change per
    // write, at the cost of one cycle of latency after the write lands.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            path_ctrl <= '0;
        else
            path_ctrl <= path_ctrl_nxt;
    end

    // ------------------------------------------------------------
    // Reference pulse handling
    // ------------------------------------------------------------
    // Decode results of the synchroniser, shared by the edge logic below.
    logic sync_agree;
    logic sync_rise;

    // The pin is asynchronous: three stages in a row. Only the shift itself
    // reads stage one, so a metastable first stage never fans out.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            sync_sr_r <= 3'h0;
        else
            sync_sr_r <= {sync_sr_r[1:0], sync_pulse_in};
    end

    // A level counts once stages two and three agree, which also drops a
    // glitch that is seen by a single sample only.
    assign sync_agree = stages_agree(sync_sr_r);

    // Last accepted level of the pin. It resets low, the idle level of the
    // reference, so no false rise follows a reset.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            sync_seen_r <= 1'b0;
        else if (sync_agree)
            sync_seen_r <= sync_sr_r[2];
    end

    // One-cycle marker of an accepted rising level.
    assign sync_rise = sync_agree && sync_sr_r[2] && !sync_seen_r;

    // ------------------------------------------------------------
    // Divider reset and sample tagging
    // ------------------------------------------------------------
    // In timestamp mode the pulse never resets the dividers, so the serial
    // link and the signal monitor run on undisturbed.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            divider_reset <= 1'b0;
        else
            divider_reset <= sync_rise && !timestamp_mode;
    end

    // A pulse that meets no sample waits here for the next valid one. A pulse
    // that meets a sample tags it at once and leaves nothing pending, so one
    // pulse can never mark two samples. Leaving timestamp mode drops a wait.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            tag_pending_r <= 1'b0;
        else if (timestamp_mode && sync_rise && !sample_valid)
            tag_pending_r <= 1'b1;
        else if (sample_valid || !timestamp_mode)
            tag_pending_r <= 1'b0;
    end

    // The tag is a registered pulse in the cycle after the tagged sample.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            sample_tag <= 1'b0;
        else
            sample_tag <= sample_valid && timestamp_mode && (tag_pending_r || sync_rise);
    end

    // Running count of tagged samples. It wraps at 255 with no flag, so
    // software that polls it must read it at least once per 255 pulses
    // to keep an exact tally.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            tag_count_r <= 8'h00;
        else if (sample_tag)
            tag_count_r <= tag_count_r + 8'h01;
    end

endmodule // chip_mode_config

/* File: dv/chip_mode_monitor.sv */
`timescale 1ns/10ps
// Watches the mode outputs and the sync pulse path; reset disables every check.
module chip_mode_monitor
(
    input wire logic                         core_clk,
    input wire logic                         rstn,
    input wire logic [11:0]                  reg_addr,
    input wire logic [7:0]                   reg_wdata,
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [7:0]                   reg_rdata,
    input wire logic                         timestamp_mode,
    input wire logic                         sync_pulse_in,
    input wire logic                         sample_valid,
    input wire chip_mode_pkg::path_ctrl_type path_ctrl,
    input wire logic                         sample_tag,
    input wire logic                         divider_reset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire op_wr = reg_wr && reg_addr == chip_mode_pkg::ADDR_OPERATING_MODE;
    q_path_a: assert property (op_wr |-> ##2 path_ctrl.q_path_enable == !$past(reg_wdata[5], 2))
        else $error("quadrature enable wrong");
    two_path_a: assert property (op_wr && reg_wdata[3:0] == chip_mode_pkg::APP_TWO_PATHS |-> ##2
        (path_ctrl.decimation_code == chip_mode_pkg::DECIM_BYPASS
            || (path_ctrl.first_downconverter_en && path_ctrl.second_downconverter_en))) else $error("paths off");
    bypass_a: assert property ($past(rstn) && path_ctrl.decimation_code == 4'h0
        |-> path_ctrl.downconverter_bypass && !path_ctrl.first_downconverter_en) else $error("no bypass");
    no_divider_a: assert property (timestamp_mode [*6] |-> !divider_reset) else $error("divider pulse");
    tag_cause_a: assert property (sample_tag |-> $past(sample_valid) && $past(timestamp_mode))
        else $error("stray tag");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
endmodule // chip_mode_monitor

/* File: dv/test_chip_mode_config.sv */
`timescale 1ns/10ps
module test_chip_mode_config;
    logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, timestamp_mode = 0, sync_pulse_in = 0, sample_valid = 0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
    logic sample_tag, divider_reset, div, tag;
    chip_mode_pkg::path_ctrl_type path_ctrl;
    int bad_count = 0, n_checks = 0;
    chip_mode_config i_dut
    (
        .core_clk       (core_clk),
        .rstn           (rstn),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .timestamp_mode (timestamp_mode),
        .sync_pulse_in  (sync_pulse_in),
        .sample_valid   (sample_valid),
        .path_ctrl      (path_ctrl),
        .sample_tag     (sample_tag),
        .divider_reset  (divider_reset)
    );
    // ----------------------------------------
    // Bus and checking helpers
    // ----------------------------------------
    initial forever #5 core_clk = ~core_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task rd(input logic [11:0] a);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
    endtask
    // The pulse window is fixed, so a missing pulse shows as a mismatch, never a hang.
    task sync_run(input logic ts);
        div = 0;
        tag = 0;
        timestamp_mode <= ts;
        sample_valid <= ts;
        repeat (8) @(posedge core_clk);
        sync_pulse_in <= 1'h1;
        repeat (12)
        begin
            @(posedge core_clk);
            #1;
            div |= divider_reset;
            tag |= sample_tag;
        end
        sync_pulse_in <= 1'h0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task regs_scn;
        rd(12'h200); chk(v, 8'h00);
        rd(12'h201); chk(v, 8'h00);
        wr(12'h200, 8'hff);
        wr(12'h201, 8'hff);
        wr(12'h203, 8'hff);
        rd(12'h200); chk(v, 8'h2f);
        rd(12'h201); chk(v, 8'h0f);
        rd(12'h202); chk(v, 8'h00);
    endtask
    task paths_scn;
        wr(12'h201, 8'h03);
        wr(12'h200, 8'h02);
        @(posedge core_clk) #1 chk(path_ctrl, 8'he3);
        wr(12'h201, 8'h00);
        @(posedge core_clk) #1 chk(path_ctrl, 8'h90);
        wr(12'h200, 8'h20);
        @(posedge core_clk) #1 chk(path_ctrl, 8'h10);
    endtask
    task sync_scn;
        sync_run(1'h0);
        chk({6'h00, div, tag}, 8'h02);
        sync_run(1'h1);
        chk({6'h00, div, tag}, 8'h01);
        rd(12'h202); chk(v, 8'h01);
    endtask
    // A pulse that meets no sample waits for the next one and marks it alone.
    task wait_scn;
        sample_valid <= 1'h0;
        repeat (8) @(posedge core_clk);
        sync_pulse_in <= 1'h1;
        repeat (8) @(posedge core_clk);
        #1 chk({7'h00, sample_tag}, 8'h00);
        @(posedge core_clk);
        sample_valid <= 1'h1;
        @(posedge core_clk);
        sample_valid <= 1'h0;
        #1 chk({7'h00, sample_tag}, 8'h01);
        @(posedge core_clk) #1 chk({7'h00, sample_tag}, 8'h00);
        sync_pulse_in <= 1'h0;
        rd(12'h202); chk(v, 8'h02);
    endtask
    // A reset in mid-run brings back every default, the tag count too.
    task reset_scn;
        @(posedge core_clk);
        rstn <= 1'h0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'h1;
        @(posedge core_clk) #1 chk(path_ctrl, 8'h90);
        rd(12'h202); chk(v, 8'h00);
        rd(12'h200); chk(v, 8'h00);
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'h1;
        regs_scn;
        paths_scn;
        sync_scn;
        wait_scn;
        reset_scn;
        give_verdict;
    end
endmodule // test_chip_mode_config
bind chip_mode_config chip_mode_monitor i_mon
(
    .core_clk       (core_clk),
    .rstn           (rstn),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .timestamp_mode (timestamp_mode),
    .sync_pulse_in  (sync_pulse_in),
    .sample_valid   (sample_valid),
    .path_ctrl      (path_ctrl),
    .sample_tag     (sample_tag),
    .divider_reset  (divider_reset)
);
